//--- hw/eia_pkg.sv
// Package with offsets, field positions, reset values and carriers.
package eia_pkg;
    // Register offsets on the control page.
    localparam logic [4:0] ERR_DEBOUNCE_OFS = 5'h10;
    localparam logic [4:0] ACCESS_SEL_OFS   = 5'h13;
    // Error and debounce word fields.
    localparam int BPV_BIT   = 7;
    localparam int CRC_BIT   = 6;
    localparam int FAS_BIT   = 5;
    localparam int NFAS_BIT  = 4;
    localparam int MUTE_BIT  = 3; // Forced signal loss.
    localparam int PAY_BIT   = 2;
    localparam int DBNC_BIT  = 0;
    // Access select word fields.
    localparam int LSRC_BIT  = 2;
    localparam int SEQ_BIT   = 1;
    localparam int FPF_BIT   = 0;
    // Reset values and writable masks.
    localparam logic [7:0] ERR_DEBOUNCE_RST = 8'h00;
    localparam logic [7:0] ACCESS_SEL_RST   = 8'h00;
    localparam logic [7:0] ERR_DEBOUNCE_MSK = 8'hFD;
    localparam logic [7:0] ACCESS_SEL_MSK   = 8'h07;
    // Debounce timing.
    localparam int DEBOUNCE_MS      = 14;
    localparam int DEBOUNCE_SLIP_MS = 2;
    localparam int CLK_MHZ          = 100;
    localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * 1000 * CLK_MHZ;

    // One-cycle injection requests toward the transmit path.
    typedef struct packed {
        logic bipolarViolation;
        logic checksumError;
        logic alignmentWord;
        logic nonAlignmentWord;
        logic payloadError;
    } eia_inject_t;

    // Static transmit and backplane controls.
    typedef struct packed {
        logic forcedSignalLoss;
        logic debounceSelect;
        logic testSequenceSelect;
        logic framePulseFormat;
    } eia_mode_t;
endpackage

//--- hw/eia_regs.sv
// Error insertion and access select control registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - A rising bipolar violation inject bit inserts one bipolar violation.
// - A rising checksum error inject bit corrupts exactly one CRC-4 check.
// - A rising alignment word inject bit puts one error in that word.
// - A rising non-alignment inject bit inverts bit two of one such word.
// - Forced signal loss one sends no pulses, zero sends data normally.
// - A rising payload inject bit introduces one payload error.
// - Steady levels or a falling change of an inject bit do nothing.
// - Debounce select one gives a 14 ms debounce, zero gives none; the module only outputs the select level, DEBOUNCE_CYCLES is unused.
// - The real debounce may exceed the period by up to 2 ms.
// - Loss source select one drives the loss pin from line loss alone.
// - Test sequence select one picks the digital milliwatt sequence.
// - Test sequence select zero picks the 2^15-1 pseudo-random sequence.
// - Writing one to test sequence select resets the sequence generator.
// - Frame pulse format one selects the GCI frame pulse, else the other.
module eia_regs #(
    parameter int DEBOUNCE_CYCLES = eia_pkg::DEBOUNCE_CYC
) (
    input  wire logic              clk,            // System clock.
    input  wire logic              rst_n,          // Async reset, low.
    input  wire logic [4:0]        addr,           // Register address.
    input  wire logic [7:0]        wrData,         // Write data.
    input  wire logic              wrEn,           // Write strobe.
    input  wire logic              rdEn,           // Read strobe.
    output logic [7:0]             rdData,         // Read data.
    input  wire logic              lineLossStatus, // Line loss, async.
    input  wire logic              frameAligned,   // Basic alignment, async.
    output eia_pkg::eia_inject_t   inject,         // One-cycle requests.
    output eia_pkg::eia_mode_t     mode,           // Static controls.
    output logic                   prbsReset,      // Generator reset pulse.
    output logic                   lossIndication  // Loss pin level.
);
    logic [7:0]  errReg;
    logic [7:0]  accReg;
    logic [7:0]  errNext;
    logic        lossSync1Reg;
    logic        lossSync2Reg;
    logic        alignSync1Reg;
    logic        alignSync2Reg;
    eia_pkg::eia_inject_t injectNext;

    // Address decode of the two writable words.
    wire wrErr = wrEn && (addr == eia_pkg::ERR_DEBOUNCE_OFS);
    wire wrAcc = wrEn && (addr == eia_pkg::ACCESS_SEL_OFS);
    assign errNext = wrData & eia_pkg::ERR_DEBOUNCE_MSK;

    // Rising bits of the new value against the held value.
    wire [7:0] riseBits = wrErr ? (errNext & ~errReg) : 8'h00;
    assign injectNext.bipolarViolation = riseBits[eia_pkg::BPV_BIT];
    assign injectNext.checksumError    = riseBits[eia_pkg::CRC_BIT];
    assign injectNext.alignmentWord    = riseBits[eia_pkg::FAS_BIT];
    assign injectNext.nonAlignmentWord = riseBits[eia_pkg::NFAS_BIT];
    assign injectNext.payloadError     = riseBits[eia_pkg::PAY_BIT];

    // Loss source selection on synchronised status levels.
    wire lossNext = accReg[eia_pkg::LSRC_BIT] ? lossSync2Reg
                  : (lossSync2Reg | ~alignSync2Reg);
    wire [7:0] rdMux = (addr == eia_pkg::ERR_DEBOUNCE_OFS) ? errReg
                     : (addr == eia_pkg::ACCESS_SEL_OFS) ? accReg : 8'h00;

    // Register storage; unmapped writes are dropped.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            errReg <= eia_pkg::ERR_DEBOUNCE_RST;
            accReg <= eia_pkg::ACCESS_SEL_RST;
        end else begin
            if (wrErr) errReg <= errNext;
            if (wrAcc) accReg <= wrData & eia_pkg::ACCESS_SEL_MSK;
        end
    end

    // Two-stage synchronisers for the status inputs from the line side.
    // Alignment resets to its idle level, so no false loss follows reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lossSync1Reg  <= 1'b0;
            lossSync2Reg  <= 1'b0;
            alignSync1Reg <= 1'b1;
            alignSync2Reg <= 1'b1;
        end else begin
            lossSync1Reg  <= lineLossStatus;
            lossSync2Reg  <= lossSync1Reg;
            alignSync1Reg <= frameAligned;
            alignSync2Reg <= alignSync1Reg;
        end
    end

    // Outputs are registered so the transmit path sees clean pulses.
    // The multiframe slip of up to 2 ms lives in the signalling path.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            inject         <= '0;
            mode           <= '0;
            prbsReset      <= 1'b0;
            lossIndication <= 1'b0;
            rdData         <= 8'h00;
        end else begin
            inject <= injectNext;
            mode.forcedSignalLoss   <= errReg[eia_pkg::MUTE_BIT];
            mode.debounceSelect     <= errReg[eia_pkg::DBNC_BIT];
            mode.testSequenceSelect <= accReg[eia_pkg::SEQ_BIT];
            mode.framePulseFormat   <= accReg[eia_pkg::FPF_BIT];
            prbsReset <= wrAcc && wrData[eia_pkg::SEQ_BIT];
            lossIndication <= lossNext;
            rdData <= rdEn ? rdMux : 8'h00;
        end
    end

    // Checks on the injection and control paths.
    property p_inject_once;
        @(posedge clk) disable iff (!rst_n)
        inject.bipolarViolation |=> !inject.bipolarViolation;
    endproperty
    a_inject_once: assert property (p_inject_once)
        else $error("Bipolar inject lasted more than one cycle.");

    property p_bpv_rise;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && wrData[eia_pkg::BPV_BIT] && !errReg[eia_pkg::BPV_BIT])
            |=> inject.bipolarViolation;
    endproperty
    a_bpv_rise: assert property (p_bpv_rise)
        else $error("Bipolar inject missing after rising write.");

    property p_crc_rise;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && wrData[eia_pkg::CRC_BIT] && !errReg[eia_pkg::CRC_BIT])
            |=> inject.checksumError;
    endproperty
    a_crc_rise: assert property (p_crc_rise)
        else $error("Checksum inject missing after rising write.");

    // A pulse must trace back to a write that raised the bit.
    property p_fas_cause;
        @(posedge clk) disable iff (!rst_n)
        inject.alignmentWord |-> $past(wrErr)
            && $past(wrData[eia_pkg::FAS_BIT])
            && !$past(errReg[eia_pkg::FAS_BIT]);
    endproperty
    a_fas_cause: assert property (p_fas_cause)
        else $error("Alignment inject without rising write.");

    property p_nfas_rise;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && wrData[eia_pkg::NFAS_BIT] && !errReg[eia_pkg::NFAS_BIT])
            |=> inject.nonAlignmentWord;
    endproperty
    a_nfas_rise: assert property (p_nfas_rise)
        else $error("Non-alignment inject missing.");

    property p_pay_rise;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && wrData[eia_pkg::PAY_BIT] && !errReg[eia_pkg::PAY_BIT])
            |=> inject.payloadError;
    endproperty
    a_pay_rise: assert property (p_pay_rise)
        else $error("Payload inject missing after rising write.");

    property p_forced_loss;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && wrData[eia_pkg::MUTE_BIT]) |=> ##1 mode.forcedSignalLoss;
    endproperty
    a_forced_loss: assert property (p_forced_loss)
        else $error("Forced loss not applied.");

    property p_forced_off;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && !wrData[eia_pkg::MUTE_BIT]) |=> ##1 !mode.forcedSignalLoss;
    endproperty
    a_forced_off: assert property (p_forced_off)
        else $error("Forced loss still applied after clearing.");

    property p_pay_steady;
        @(posedge clk) disable iff (!rst_n)
        (wrErr && errReg[eia_pkg::PAY_BIT]) |=> !inject.payloadError;
    endproperty
    a_pay_steady: assert property (p_pay_steady)
        else $error("Payload inject on steady or falling bit.");

    // The level seen two edges on is the bit that was written.
    property p_debounce;
        @(posedge clk) disable iff (!rst_n)
        wrErr |=> ##1 (mode.debounceSelect
            == $past(wrData[eia_pkg::DBNC_BIT], 2));
    endproperty
    a_debounce: assert property (p_debounce)
        else $error("Debounce select does not follow the write.");

    property p_loss_line;
        @(posedge clk) disable iff (!rst_n)
        (accReg[eia_pkg::LSRC_BIT] && !lossSync2Reg) |=> !lossIndication;
    endproperty
    a_loss_line: assert property (p_loss_line)
        else $error("Loss pin high without line loss.");

    property p_loss_frame;
        @(posedge clk) disable iff (!rst_n)
        (!accReg[eia_pkg::LSRC_BIT] && !alignSync2Reg) |=> lossIndication;
    endproperty
    a_loss_frame: assert property (p_loss_frame)
        else $error("Loss pin low during lost alignment.");

    property p_loss_both;
        @(posedge clk) disable iff (!rst_n)
        (!accReg[eia_pkg::LSRC_BIT] && lossSync2Reg) |=> lossIndication;
    endproperty
    a_loss_both: assert property (p_loss_both)
        else $error("Loss pin low during line loss.");

    property p_prbs;
        @(posedge clk) disable iff (!rst_n)
        (wrAcc && wrData[eia_pkg::SEQ_BIT])
            |=> prbsReset ##1 mode.testSequenceSelect;
    endproperty
    a_prbs: assert property (p_prbs)
        else $error("Generator reset or sequence select missing.");

    property p_seq_off;
        @(posedge clk) disable iff (!rst_n)
        (wrAcc && !wrData[eia_pkg::SEQ_BIT])
            |=> !prbsReset ##1 !mode.testSequenceSelect;
    endproperty
    a_seq_off: assert property (p_seq_off)
        else $error("Pseudo-random sequence not selected.");

    property p_frame_pulse;
        @(posedge clk) disable iff (!rst_n)
        wrAcc |=> ##1 (mode.framePulseFormat
            == $past(wrData[eia_pkg::FPF_BIT], 2));
    endproperty
    a_frame_pulse: assert property (p_frame_pulse)
        else $error("Frame pulse format does not follow the write.");

    c_bpv: cover property (@(posedge clk) inject.bipolarViolation);
    c_payload: cover property (@(posedge clk) inject.payloadError);
    c_forced: cover property (@(posedge clk) mode.forcedSignalLoss);
    c_loss: cover property (@(posedge clk) lossIndication);
    c_prbs: cover property (@(posedge clk) prbsReset);
endmodule
`default_nettype wire

//--- test/eia_host_model.sv
// Host processor model that drives the parallel register bus.
`timescale 1ns/1ps
`default_nettype none
module eia_host_model (
    input  wire logic       clk,    // System clock.
    output logic [4:0]      addr,   // Register address.
    output logic [7:0]      wrData, // Write data.
    output logic            wrEn,   // Write strobe.
    output logic            rdEn,   // Read strobe.
    input  wire logic [7:0] rdData  // Read data.
);
    // The bus starts idle with both strobes low.
    initial begin
        addr = 5'h00;
        wrData = 8'h00;
        wrEn = 1'h0;
        rdEn = 1'h0;
    end
    // Idle data is inverted so that a late sample of it is caught.
    task automatic write(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'h1;
        @(posedge clk);
        wrEn   <= 1'h0;
        wrData <= ~d;
    endtask
    // Read data is registered, so it is taken one cycle after the strobe.
    task automatic read(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'h1;
        @(posedge clk);
        rdEn <= 1'h0;
        #1 d = rdData;
    endtask
endmodule
`default_nettype wire

//--- test/eia_regs_tb.sv
// Self-checking bench for the error insertion and access select registers.
`timescale 1ns/1ps
`default_nettype none
module eia_regs_tb;
    typedef struct packed {
        logic [4:0] a;
        logic [7:0] d;
        logic [4:0] inj;
        logic [3:0] md;
        logic       p;
        logic [7:0] rd;
    } eia_row_t;
    // Address, data, then pulses, levels, generator reset and read back.
    localparam eia_row_t ROWS [11] = '{
        '{5'h10, 8'h80, 5'h10, 4'h0, 1'h0, 8'h80},
        '{5'h10, 8'h80, 5'h00, 4'h0, 1'h0, 8'h80},
        '{5'h10, 8'h40, 5'h08, 4'h0, 1'h0, 8'h40},
        '{5'h10, 8'h20, 5'h04, 4'h0, 1'h0, 8'h20},
        '{5'h10, 8'h10, 5'h02, 4'h0, 1'h0, 8'h10},
        '{5'h10, 8'h04, 5'h01, 4'h0, 1'h0, 8'h04},
        '{5'h10, 8'h0B, 5'h00, 4'hC, 1'h0, 8'h09},
        '{5'h13, 8'hFE, 5'h00, 4'hE, 1'h1, 8'h06},
        '{5'h13, 8'h03, 5'h00, 4'hF, 1'h1, 8'h03},
        '{5'h11, 8'hFF, 5'h00, 4'hF, 1'h0, 8'h00},
        '{5'h10, 8'h7F, 5'h0F, 4'hF, 1'h0, 8'h7D}};
    logic                 clk = 1'h0;
    logic                 rst_n = 1'h0;
    logic                 lineLossStatus = 1'h0;
    logic                 frameAligned = 1'h1;
    logic                 wrEn, rdEn, prbsReset, lossIndication;
    logic [4:0]           addr;
    logic [7:0]           wrData, rdData, got;
    eia_pkg::eia_inject_t inject;
    eia_pkg::eia_mode_t   mode;
    int                   failures = 0;
    int                   checks = 0;
    int                   cycles = 0;
    // The debounce count is not used by the module; only the select level shows here.
    eia_regs #(.DEBOUNCE_CYCLES(100)) DUT (.clk, .rst_n, .addr, .wrData,
        .wrEn, .rdEn, .rdData, .lineLossStatus, .frameAligned, .inject,
        .mode, .prbsReset, .lossIndication);
    eia_host_model host (.clk, .addr, .wrData, .wrEn, .rdEn, .rdData);
    always #5 clk = ~clk;
    // Cuts a hang short; the whole run needs about a hundred cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failures++;
            conclude();
        end
    end
    task automatic check(input string n, input logic [7:0] e,
                         input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One compare per kind of result, so every miss names its signal.
    task automatic checkInject(input logic [4:0] e);
        checks++;
        if (inject !== e) begin
            failures++;
            $display("Error inject expected %h seen %h", e, inject);
        end
    endtask
    task automatic checkMode(input logic [3:0] e);
        checks++;
        if (mode !== e) begin
            failures++;
            $display("Error mode expected %h seen %h", e, mode);
        end
    endtask
    task automatic checkBit(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // The status path has three edges of latency; four are allowed.
    task automatic lossCase(input logic l, input logic a, input logic e);
        @(posedge clk);
        lineLossStatus <= l;
        frameAligned   <= a;
        repeat (4) @(posedge clk);
        #1 checkBit("lossIndication", e, lossIndication);
    endtask
    task automatic conclude();
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        // Alignment is high from the start, so no loss may show after reset.
        @(posedge clk);
        #1 checkBit("lossIndication", 1'h0, lossIndication);
        foreach (ROWS[i]) begin
            host.write(ROWS[i].a, ROWS[i].d);
            #1 checkInject(ROWS[i].inj);
            checkBit("prbsReset", ROWS[i].p, prbsReset);
            @(posedge clk);
            #1 checkMode(ROWS[i].md);
            checkInject(5'h00);
            host.read(ROWS[i].a, got);
            check("rdData", ROWS[i].rd, got);
        end
        lossCase(1'h0, 1'h1, 1'h0);
        lossCase(1'h1, 1'h1, 1'h1);
        lossCase(1'h0, 1'h0, 1'h1);
        host.write(5'h13, 8'h04);
        lossCase(1'h0, 1'h0, 1'h0);
        lossCase(1'h1, 1'h0, 1'h1);
        // A second reset in mid-run must clear both registers.
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        #1 checkMode(4'h0);
        checkInject(5'h00);
        checkBit("lossIndication", 1'h0, lossIndication);
        host.read(5'h10, got);
        check("rdData", 8'h00, got);
        host.read(5'h13, got);
        check("rdData", 8'h00, got);
        // Select is zero again, and line loss with lost alignment shows.
        checkBit("lossIndication", 1'h1, lossIndication);
        conclude();
    end
endmodule
`default_nettype wire
